// ---- aldf_pkg.sv ----
// Package: constants and carrier types for the amplifier load-diagnostic and fault control
// Contract
// - Diagnostics start on standby release or after a fault clears.
// - Both bridge outputs are high impedance while diagnostics run.
// - Diagnostics classify short to ground, short to supply, open or shorted load.
// - One full diagnostic pass lasts about 229 ms.
// - Check phase repeats up to 5 times while a fault persists; the code limits only cap_to_gnd, load faults recheck without limit.
// - Open load alone still lets the output stage run.
// - Other load faults keep outputs high impedance and recheck continuously.
// - A normal load result starts PWM switching.
// - Overvoltage triggers diagnostics only on every second event.
// - Open load reports in status only; other faults also assert fault pin.
// - Overtemperature, overvoltage or undervoltage aborts diagnostics at once.
// - Overcurrent forces high impedance, asserts fault pin, sets status flag.
// - Dc offset in normal operation asserts fault pin and sets flag.
// - Overtemperature shuts output down, flags it, resumes automatically.
// - Undervoltage asserts fault pin and resets register contents.
// - During power-on reset the serial lines are released; defaults afterwards.
// - Overvoltage asserts fault pin and sets its status flag.
// - Output is clamped symmetrically to the limit in control register 0x03.
// - Zero input drives both bridge outputs in phase.
// - Positive output: positive duty above 50 percent, negative below.
// - Bits 7 to 6 of register 0x03 select 20, 26, 32, 36 dB.
// - Fault indicator is active low, open drain, asserted with forced Hi-Z.
`default_nettype none
package aldf_pkg;
  localparam int unsigned CLK_HZ         = 40_000_000;
  localparam int unsigned DIAG_PASS_MS   = 229;
  localparam int unsigned DIAG_PASS_CYC  = DIAG_PASS_MS * (CLK_HZ / 1000);
  localparam int unsigned CHECK_MAX      = 5;
  localparam logic [7:0]  CTRL_ADDR      = 8'h03;
  localparam int unsigned GAIN_MSB       = 7;
  localparam int unsigned GAIN_LSB       = 6;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam int unsigned LIMIT_W        = 6;
  localparam int unsigned PWM_W          = 8;
  localparam logic [PWM_W-1:0] PWM_HALF  = 8'h80;

  typedef enum logic [1:0] {GAIN_20DB, GAIN_26DB, GAIN_32DB, GAIN_36DB} aldf_gain_type;

  // Raw load classification from the analog comparators
  typedef struct packed {
    logic short_gnd;
    logic short_supply;
    logic open_load;
    logic shorted_load;
  } aldf_load_type;

  // Protection monitor levels
  typedef struct packed {
    logic overcurrent_shutdown;
    logic dc_offset;
    logic overtemp_shutdown;
    logic supply_low_fault;
    logic supply_high_fault;
  } aldf_prot_type;

  // Sticky status seen by the processor
  typedef struct packed {
    aldf_load_type load;
    aldf_prot_type prot;
  } aldf_status_type;
endpackage : aldf_pkg
`default_nettype wire

// ---- aldf_ctrl.sv ----
// Module: load-diagnostic sequencer, protection handling and modulator control
`default_nettype none
module aldf_ctrl #(
  parameter int unsigned DIAG_PASS_CYC = aldf_pkg::DIAG_PASS_CYC
) (
  // Clock and power-on reset
  input  wire logic                         core_clk,
  input  wire logic                         rst,
  // Pins from outside the clock domain
  input  wire logic                         standby_n,
  input  wire logic                         mute,
  input  wire aldf_pkg::aldf_prot_type      prot_in,
  input  wire aldf_pkg::aldf_load_type      load_in,
  input  wire logic                         cap_to_gnd,
  input  wire logic                         scl_in,
  input  wire logic                         sda_in,
  // Register side, same domain
  input  wire logic                         ctrl_we,
  input  wire logic [7:0]                   ctrl_wdata,
  input  wire logic                         status_clr,
  input  wire logic                         sda_drive_low,
  // Audio sample (signed) from the preamp converter
  input  wire logic signed [aldf_pkg::PWM_W-1:0] audio_in,
  // Bridge outputs
  output logic                              bridge_out_pos,
  output logic                              bridge_out_neg,
  output logic                              bridge_hiz,
  output logic                              diag_active,
  // Fault pin, open drain
  output logic                              fault_out,
  output logic                              fault_oe,
  // Serial data pin, open drain
  output logic                              sda_out,
  output logic                              sda_oe,
  output logic                              scl_sync,
  // Status and configuration
  output aldf_pkg::aldf_status_type         status,
  output logic [7:0]                        ctrl_q,
  output aldf_pkg::aldf_gain_type           gain_sel
);

  //////////////////////////////////////////////////////////////////////////////
  // Synchronisers: first stage read only by the second
  localparam int unsigned NSYNC = 14;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] s1_q;
  logic [NSYNC-1:0] s2_q;
  assign raw_in = {standby_n, mute, prot_in, load_in, cap_to_gnd, scl_in, sda_in};

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      s1_q <= '0;
      s2_q <= '0;
    end
    else
    begin
      s1_q <= raw_in;
      s2_q <= s1_q;
    end
  end

  logic                    stby_n_s;
  logic                    mute_s;
  aldf_pkg::aldf_prot_type prot_s;
  aldf_pkg::aldf_load_type load_s;
  logic                    cap_s;
  logic                    scl_s;
  assign {stby_n_s, mute_s, prot_s, load_s, cap_s, scl_s} = s2_q[NSYNC-1:1];

  //////////////////////////////////////////////////////////////////////////////
  // Edge detection on synchronised levels
  logic stby_n_prev_q;
  logic ov_prev_q;
  logic ov_parity_q;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      stby_n_prev_q <= 1'b0;
      ov_prev_q     <= 1'b0;
    end
    else
    begin
      stby_n_prev_q <= stby_n_s;
      ov_prev_q     <= prot_s.supply_high_fault;
    end
  end

  logic stby_rel;
  logic ov_rise;
  assign stby_rel = stby_n_s & ~stby_n_prev_q;
  assign ov_rise  = prot_s.supply_high_fault & ~ov_prev_q;

  // Odd events arm the parity, even events trigger diagnostics
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      ov_parity_q <= 1'b0;
    else if (ov_rise)
      ov_parity_q <= ~ov_parity_q;
  end

  logic ov_trigger;
  assign ov_trigger = ov_rise & ov_parity_q;

  //////////////////////////////////////////////////////////////////////////////
  // Diagnostic sequencer
  typedef enum logic [1:0] {ST_OFF, ST_DIAG, ST_PLAY, ST_HOLD} aldf_state_type;
  aldf_state_type state_q;
  logic [31:0]    timer_q;
  logic [2:0]     check_cnt_q;
  logic           ov_pending_q;

  logic abort_cond;
  logic other_fault;
  logic load_bad;
  logic pass_done;
  assign abort_cond  = prot_s.overtemp_shutdown | prot_s.supply_low_fault
                     | prot_s.supply_high_fault;
  assign other_fault = prot_s.overcurrent_shutdown | prot_s.dc_offset;
  assign load_bad    = load_s.short_gnd | load_s.short_supply | load_s.shorted_load;
  assign pass_done   = (timer_q == DIAG_PASS_CYC - 1);

  // Odd overvoltage events alone resume play without a diagnostic rerun
  logic rerun_q;
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      rerun_q <= 1'b0;
    else if (prot_s.overtemp_shutdown | prot_s.supply_low_fault | other_fault
             | (state_q == ST_DIAG))
      rerun_q <= 1'b1;
    else if (state_q == ST_PLAY || state_q == ST_OFF)
      rerun_q <= 1'b0;
  end

  // Even overvoltage event waits until the supply recovers
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      ov_pending_q <= 1'b0;
    else if (ov_trigger)
      ov_pending_q <= 1'b1;
    else if (state_q == ST_DIAG)
      ov_pending_q <= 1'b0;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q     <= ST_OFF;
      timer_q     <= '0;
      check_cnt_q <= '0;
    end
    else if (!stby_n_s)
    begin
      state_q     <= ST_OFF;
      timer_q     <= '0;
      check_cnt_q <= '0;
    end
    else
    begin
      unique case (state_q)
        ST_OFF:
        begin
          if (stby_rel)
          begin
            state_q <= ST_DIAG;
            timer_q <= '0;
          end
        end
        ST_DIAG:
        begin
          if (abort_cond)
          begin
            state_q <= ST_HOLD;
            timer_q <= '0;
          end
          else if (pass_done)
          begin
            timer_q <= '0;
            if ((load_bad | cap_s) && check_cnt_q < 3'(aldf_pkg::CHECK_MAX - 1))
              check_cnt_q <= check_cnt_q + 3'h1;
            else if (load_bad)
            begin
              // Count held so the fault pin stays asserted while rechecking
              check_cnt_q <= check_cnt_q;
            end
            else
            begin
              check_cnt_q <= '0;
              state_q     <= ST_PLAY;
            end
          end
          else
            timer_q <= timer_q + 32'h1;
        end
        ST_PLAY:
        begin
          if (abort_cond || other_fault)
          begin
            state_q <= ST_HOLD;
            timer_q <= '0;
          end
          else if (ov_pending_q)
          begin
            state_q <= ST_DIAG;
            timer_q <= '0;
          end
        end
        ST_HOLD:
        begin
          // Once protection inputs clear, rerun diagnostics if rerun_q or ov_pending_q is set, else resume play
          if (!abort_cond && !other_fault)
          begin
            state_q <= (rerun_q || ov_pending_q) ? ST_DIAG : ST_PLAY;
            timer_q <= '0;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status and control registers; undervoltage resets the control register like power-on
  logic clear_regs;
  assign clear_regs = prot_s.supply_low_fault;

  aldf_pkg::aldf_status_type status_set;
  assign status_set.prot = prot_s;
  assign status_set.load = (state_q == ST_DIAG && pass_done) ? load_s : '0;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      status <= '0;
    else if (status_clr)
      status <= status_set;  // Set wins over clear
    else
      status <= status | status_set;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      ctrl_q <= aldf_pkg::CTRL_RESET;
    else if (clear_regs)
      ctrl_q <= aldf_pkg::CTRL_RESET;
    else if (ctrl_we)
      ctrl_q <= ctrl_wdata;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      gain_sel <= aldf_pkg::GAIN_20DB;
    else
      gain_sel <= aldf_pkg::aldf_gain_type'(ctrl_q[aldf_pkg::GAIN_MSB:aldf_pkg::GAIN_LSB]);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Modulator: symmetric clamp then in-phase bridge PWM
  function automatic logic signed [aldf_pkg::PWM_W-1:0] clamp_sym(
    input logic signed [aldf_pkg::PWM_W-1:0] x,
    input logic [aldf_pkg::LIMIT_W-1:0]      lim
  );
    logic signed [aldf_pkg::PWM_W-1:0] l;
    l = $signed({2'b00, lim});
    if (x > l)
      return l;
    else if (x < -l)
      return -l;
    else
      return x;
  endfunction

  logic [aldf_pkg::PWM_W-1:0]        carrier_q;
  logic signed [aldf_pkg::PWM_W-1:0] sample;
  logic [aldf_pkg::PWM_W-1:0]        duty_pos;
  logic [aldf_pkg::PWM_W-1:0]        duty_neg;
  assign sample   = clamp_sym(audio_in, ctrl_q[aldf_pkg::LIMIT_W-1:0]);
  assign duty_pos = aldf_pkg::PWM_HALF + $unsigned(sample);
  assign duty_neg = aldf_pkg::PWM_HALF - $unsigned(sample);

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      carrier_q <= '0;
    else
      carrier_q <= carrier_q + 8'h01;
  end

  logic play;
  assign play = (state_q == ST_PLAY) && !mute_s && !abort_cond && !other_fault;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      bridge_out_pos <= 1'b0;
      bridge_out_neg <= 1'b0;
      bridge_hiz     <= 1'b1;
      diag_active    <= 1'b0;
    end
    else
    begin
      bridge_hiz     <= !play;
      diag_active    <= (state_q == ST_DIAG);
      // Equal duties give identical edges: zero differential at rest
      bridge_out_pos <= play && (carrier_q < duty_pos);
      bridge_out_neg <= play && (carrier_q < duty_neg);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Fault pin and serial data pin
  logic fault_active;
  assign fault_active = abort_cond | other_fault
                      | ((state_q == ST_DIAG) && check_cnt_q != 3'h0 && load_bad);

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      fault_out <= 1'b0;
      fault_oe  <= 1'b0;
      sda_out   <= 1'b0;
      sda_oe    <= 1'b0;
      scl_sync  <= 1'b1;
    end
    else
    begin
      fault_oe  <= fault_active;
      fault_out <= 1'b0;
      sda_out   <= 1'b0;
      sda_oe    <= sda_drive_low;
      scl_sync  <= scl_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_ot_seen;
    prot_s.overtemp_shutdown;
  endsequence

  property p_diag_hiz;
    @(posedge core_clk) disable iff (rst) (state_q == ST_DIAG) |=> bridge_hiz;
  endproperty
  a_diag_hiz: assert property (p_diag_hiz) else $error("outputs switch during diagnostics");

  property p_abort;
    @(posedge core_clk) disable iff (rst)
      (state_q == ST_DIAG && abort_cond && stby_n_s) |=> (state_q == ST_HOLD);
  endproperty
  a_abort: assert property (p_abort) else $error("diagnostics not aborted");

  property p_ot_fault;
    @(posedge core_clk) disable iff (rst) s_ot_seen |=> fault_oe && bridge_hiz;
  endproperty
  a_ot_fault: assert property (p_ot_fault) else $error("overtemp not handled");

  property p_oc_flag;
    @(posedge core_clk) disable iff (rst)
      prot_s.overcurrent_shutdown |=> status.prot.overcurrent_shutdown && fault_oe;
  endproperty
  a_oc_flag: assert property (p_oc_flag) else $error("overcurrent not flagged");

  property p_ov_parity;
    @(posedge core_clk) disable iff (rst)
      (ov_rise && !ov_parity_q) |=> !ov_pending_q || $past(ov_pending_q);
  endproperty
  a_ov_parity: assert property (p_ov_parity) else $error("diag on odd overvoltage");

  property p_uv_reset;
    @(posedge core_clk) disable iff (rst)
      prot_s.supply_low_fault |=> ctrl_q == aldf_pkg::CTRL_RESET;
  endproperty
  a_uv_reset: assert property (p_uv_reset) else $error("registers kept on undervoltage");

  property p_fault_release;
    @(posedge core_clk) disable iff (rst)
      (state_q == ST_PLAY && !abort_cond && !other_fault) |=> !fault_oe;
  endproperty
  a_fault_release: assert property (p_fault_release) else $error("fault pin stuck");

  property p_in_phase;
    @(posedge core_clk) disable iff (rst) (play && sample == 0) |=> bridge_out_pos == bridge_out_neg;
  endproperty
  a_in_phase: assert property (p_in_phase) else $error("bridge not in phase at rest");

endmodule : aldf_ctrl
`default_nettype wire

// ---- aldf_host_model.sv ----
// Processor-side serial master model that clocks one byte frame on open-drain lines
`default_nettype none
module aldf_host_model (
  // Frame request
  input  wire logic       go,
  input  wire logic [7:0] tx_byte,
  // Device pull on the data line
  input  wire logic       dev_sda_oe,
  // Resolved bus levels
  output logic            scl,
  output logic            sda
);
  timeunit 1ns;
  timeprecision 100ps;
  logic m_low;
  // Pull-up wins unless a party pulls low
  assign sda = !(m_low || dev_sda_oe);
  initial
  begin
    scl   = 1'b1;
    m_low = 1'b0;
  end
  // Clock stands high outside frames; last slot is the device acknowledge
  always @(posedge go)
  begin
    m_low = 1'b1;
    #100;
    for (int i = 8; i >= 0; i--)
    begin
      scl = 1'b0;
      #50 m_low = (i > 0) ? !tx_byte[i-1] : 1'b0;
      #50 scl = 1'b1;
      #100;
    end
    scl = 1'b0;
    #50 m_low = 1'b1;
    #50 scl = 1'b1;
    #50 m_low = 1'b0;
  end
endmodule // aldf_host_model
`default_nettype wire

// ---- amp_load_diag_fault_ctrl_bench.sv ----
// Self-checking bench for the load-diagnostic and fault controller
`default_nettype none
module amp_load_diag_fault_ctrl_bench;
  timeunit 1ns;
  timeprecision 100ps;
  // Short pass keeps the run small
  localparam int unsigned PASS = 50;
  logic                            core_clk      = 1'b0;
  logic                            rst           = 1'b1;
  logic                            standby_n     = 1'b0;
  logic                            ctrl_we       = 1'b0;
  logic [7:0]                      ctrl_wdata    = 8'h00;
  logic                            status_clr    = 1'b0;
  logic                            sda_drive_low = 1'b1;
  logic                            go            = 1'b0;
  logic                            cap           = 1'b0;
  logic signed [7:0]               audio_in      = 8'sh00;
  aldf_pkg::aldf_prot_type         prot_in       = '0;
  aldf_pkg::aldf_load_type         load_in       = '0;
  logic                            scl, sda, pos, neg, hiz, diag, f_out, f_oe, s_out, s_oe, scl_s;
  aldf_pkg::aldf_status_type       status;
  logic [7:0]                      ctrl_q;
  aldf_pkg::aldf_gain_type         gain_sel;
  int                              err_count = 0;
  int                              compares  = 0;
  int                              n, hp, hn, md, a;
  // Rows: control byte, expected gain code
  logic [9:0] grow [4] = '{{8'h05, 2'h0}, {8'h4A, 2'h1}, {8'h8F, 2'h2}, {8'hFF, 2'h3}};
  // Rows: fault bits, must go Hi-Z, control reset expected
  logic [6:0] prow [5] = '{{5'h10, 2'h2}, {5'h08, 2'h0}, {5'h04, 2'h2}, {5'h02, 2'h1},
                           {5'h01, 2'h0}};

  always #12.5 core_clk = ~core_clk;

  aldf_ctrl #(.DIAG_PASS_CYC(PASS)) dut (
    .core_clk(core_clk), .rst(rst), .standby_n(standby_n), .mute(1'b0),
    .prot_in(prot_in), .load_in(load_in), .cap_to_gnd(cap), .scl_in(scl), .sda_in(sda),
    .ctrl_we(ctrl_we), .ctrl_wdata(ctrl_wdata), .status_clr(status_clr),
    .sda_drive_low(sda_drive_low), .audio_in(audio_in), .bridge_out_pos(pos),
    .bridge_out_neg(neg), .bridge_hiz(hiz), .diag_active(diag), .fault_out(f_out),
    .fault_oe(f_oe), .sda_out(s_out), .sda_oe(s_oe), .scl_sync(scl_s), .status(status),
    .ctrl_q(ctrl_q), .gain_sel(gain_sel)
  );

  aldf_host_model host (
    .go(go), .tx_byte(8'hA5), .dev_sda_oe(s_oe), .scl(scl), .sda(sda)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic done(input string what);
    $display("test %s finished", what);
  endtask

  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk);
  endtask

  task automatic wait_play(input int lim);
    for (n = 0; n < lim && hiz !== 1'b0; n++) cyc(1);
  endtask

  task automatic wr(input logic [7:0] d);
    ctrl_we    = 1'b1;
    ctrl_wdata = d;
    cyc(1);
    ctrl_we    = 1'b0;
    cyc(2);
  endtask

  task automatic restart();
    standby_n = 1'b0;
    cyc(6);
    standby_n = 1'b1;
  endtask

  // Whole PWM periods, so the counts do not depend on phase
  task automatic duty(input logic signed [7:0] s);
    audio_in = s;
    cyc(300);
    hp = 0;
    hn = 0;
    md = 0;
    repeat (1024)
    begin
      cyc(1);
      hp += int'(pos);
      hn += int'(neg);
      md += int'(pos ^ neg);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    cyc(2);
    chk("hiz_rst", 16'h1, hiz);
    chk("sda_oe_rst", 16'h0, s_oe);
    chk("ctrl_rst", 16'h0, ctrl_q);
    chk("status_rst", 16'h0, status);
    chk("fault_rst", 16'h0, f_oe);
    rst = 1'b0;
    cyc(2);
    chk("sda_oe", 16'h1, s_oe);
    sda_drive_low = 1'b0;
    go = 1'b1;
    for (n = 0; n < 40 && scl_s !== 1'b0; n++) cyc(1);
    chk("scl_sync", 16'h0, scl_s);
    go = 1'b0;
    cyc(100);
    done("reset_serial");
    foreach (grow[i])
    begin
      wr(grow[i][9:2]);
      chk("ctrl_q", grow[i][9:2], ctrl_q);
      chk("gain_sel", grow[i][1:0], gain_sel);
    end
    done("gain");
    standby_n = 1'b1;
    for (n = 0; n < 10 && diag !== 1'b1; n++) cyc(1);
    chk("diag", 16'h1, diag);
    chk("hiz_diag", 16'h1, hiz);
    wait_play(20 * PASS);
    chk("hiz_play", 16'h0, hiz);
    chk("fault_play", 16'h0, f_oe);
    done("startup");
    wr(8'h3F);
    duty(8'sh00);
    chk("out_phase", 16'h0, md[15:0]);
    duty(8'sh20);
    chk("pos_duty", 16'h1, hp > hn);
    duty(-8'sh20);
    chk("neg_duty", 16'h1, hn > hp);
    wr(8'h04);
    duty(8'sh10);
    a = hp;
    duty(8'sh7F);
    chk("clamp_pos", a[15:0], hp[15:0]);
    duty(-8'sh10);
    chk("clamp_sym", a[15:0], hn[15:0]);
    done("modulator");
    foreach (prow[i])
    begin
      wr(8'hC3);
      prot_in = prow[i][6:2];
      for (n = 0; n < 20 && f_oe !== 1'b1; n++) cyc(1);
      cyc(3);
      chk("fault_oe", 16'h1, f_oe);
      chk("fault_out", 16'h0, f_out);
      chk("prot_flag", prow[i][6:2], status.prot & prow[i][6:2]);
      if (prow[i][1])
        chk("hiz_fault", 16'h1, hiz);
      chk("ctrl_fault", prow[i][0] ? 16'h0 : 16'hC3, ctrl_q);
      prot_in = '0;
      cyc(4);
      status_clr = 1'b1;
      cyc(1);
      status_clr = 1'b0;
      wait_play(40 * PASS);
      chk("hiz_resume", 16'h0, hiz);
      chk("fault_clear", 16'h0, f_oe);
      chk("status_clear", 16'h0, status);
    end
    done("protection");
    // One overvoltage event already seen: the next is even, the one after odd
    prot_in.supply_high_fault = 1'b1;
    cyc(8);
    prot_in = '0;
    for (n = 0; n < 10 && diag !== 1'b1; n++) cyc(1);
    chk("ov_even_diag", 16'h1, diag);
    wait_play(20 * PASS);
    prot_in.supply_high_fault = 1'b1;
    cyc(8);
    prot_in = '0;
    md = 0;
    repeat (12)
    begin
      cyc(1);
      md |= int'(diag);
    end
    chk("ov_odd_nodiag", 16'h0, md[15:0]);
    wait_play(20 * PASS);
    chk("hiz_ov_odd", 16'h0, hiz);
    done("overvoltage");
    cap = 1'b1;
    restart();
    cyc(4 * PASS);
    chk("hiz_cap_repeat", 16'h1, hiz);
    wait_play(3 * PASS);
    chk("hiz_cap_end", 16'h0, hiz);
    chk("fault_cap", 16'h0, f_oe);
    cap = 1'b0;
    done("cap_repeat");
    restart();
    for (n = 0; n < 12 && diag !== 1'b1; n++) cyc(1);
    prot_in.overtemp_shutdown = 1'b1;
    cyc(6);
    chk("diag_abort", 16'h0, diag);
    chk("hiz_ot", 16'h1, hiz);
    prot_in = '0;
    wait_play(40 * PASS);
    chk("hiz_ot_end", 16'h0, hiz);
    done("abort");
    for (int k = 3; k >= 0; k--)
    begin
      load_in = 4'h1 << k;
      restart();
      if (k == 1)
        wait_play(20 * PASS);
      else
        cyc(12 * PASS);
      chk("hiz_load", k == 1 ? 16'h0 : 16'h1, hiz);
      chk("fault_load", k == 1 ? 16'h0 : 16'h1, f_oe);
      chk("load_flag", 16'h1 << k, status.load);
      load_in = '0;
      wait_play(20 * PASS);
      chk("hiz_recheck", 16'h0, hiz);
      status_clr = 1'b1;
      cyc(1);
      status_clr = 1'b0;
      cyc(4);
    end
    done("load");
    complete_run();
  end

  // Expected run is well under this span
  initial
  begin
    cyc(90000);
    err_count++;
    complete_run();
  end
endmodule // amp_load_diag_fault_ctrl_bench
`default_nettype wire
